//--- logic/sgc_regs.vh
// Offsets, field positions, codes and reset values of the switch global control block.
// Included by every design file of the block; definitions only.
`ifndef SGC_REGS_VH
`define SGC_REGS_VH

// Register offsets (byte addresses on the 12-bit register port) and the power budget page (address bits 11:8)
`define SGC_OFS_CTL 12'h000
`define SGC_OFS_BCV 12'h004
`define SGC_PB_PAGE 4'h1

// Control register fields
`define SGC_BIT_HOLD 2
`define SGC_BIT_UNLOCK 3
`define SGC_BIT_PBWE 4
`define SGC_POL_LO 9
`define SGC_POL_HI 10
`define SGC_BIT_BDROP 19
`define SGC_CTL_MASK 32'h0008061C

// Boot vector status field
`define SGC_BCV_HOLD 16

// Device number check policies
`define SGC_POL_ALL 2'h0
`define SGC_POL_CFG 2'h1
`define SGC_POL_NONE 2'h2

// Register access sources
`define SGC_SRC_SW 2'h0
`define SGC_SRC_SMB 2'h1
`define SGC_SRC_EEP 2'h2

// Reset values
`define SGC_RST_UNLOCK 1'h0
`define SGC_RST_PBWE 1'h0
`define SGC_RST_POL 2'h0
`define SGC_RST_BDROP 1'h0
`define SGC_RST_PBV 32'h00000000

// Port count and power budget entries per port
`define SGC_NPORT 8
`define SGC_NPBV 8

`endif

//--- logic/sgc_devnum_chk.v
// Device number check for one downstream port.
// Assumes TLP attributes arrive on the block clock, already decoded.
`timescale 1ns/10ps
`include "sgc_regs.vh"

module sgc_devnum_chk
(
    input wire clock,
    input wire rstn,
    input wire enable,
    input wire [1:0] policy,
    input wire tlp_valid,
    input wire tlp_id_routed,
    input wire tlp_cfg,
    input wire tlp_bus_hit,
    input wire [4:0] tlp_devnum,
    output reg pass_ff,
    output reg block_ff
);

    wire candidate;
    reg hit;

    assign candidate = tlp_valid & tlp_id_routed & tlp_bus_hit & (tlp_devnum != 5'h00);

    // Unused code 3 is treated as the strictest policy
    always @*
    begin
        case (policy)
            `SGC_POL_ALL: hit = candidate;
            `SGC_POL_CFG: hit = candidate & tlp_cfg;
            `SGC_POL_NONE: hit = 1'b0;
            default: hit = candidate;
        endcase
    end

    always @(posedge clock)
    begin
        if (!rstn)
        begin
            pass_ff <= 1'b0;
            block_ff <= 1'b0;
        end
        else
        begin
            pass_ff <= enable & tlp_valid & ~hit;
            block_ff <= enable & hit;
        end
    end

endmodule // sgc_devnum_chk

//--- logic/sgc_pwr_budget.v
// Power budgeting data value storage for all ports, flip-flops addressed by index.
// Assumes the caller has already qualified the write strobe.
`timescale 1ns/10ps
`include "sgc_regs.vh"

module sgc_pwr_budget
(
    input wire clock,
    input wire rstn,
    input wire wr,
    input wire [5:0] wr_index,
    input wire [3:0] wr_be,
    input wire [31:0] wr_data,
    input wire [5:0] rd_index,
    output wire [31:0] rd_data
);

    reg [31:0] value_ff [0:63];
    genvar g;

    generate
        for (g = 0; g < 64; g = g + 1)
        begin : g_entry
            localparam [5:0] ENTRY = g;
            always @(posedge clock)
            begin
                if (!rstn)
                    value_ff[g] <= `SGC_RST_PBV;
                else if (wr && (wr_index == ENTRY))
                    value_ff[g] <= {wr_be[3] ? wr_data[31:24] : value_ff[g][31:24],
                                    wr_be[2] ? wr_data[23:16] : value_ff[g][23:16],
                                    wr_be[1] ? wr_data[15:8] : value_ff[g][15:8],
                                    wr_be[0] ? wr_data[7:0] : value_ff[g][7:0]};
            end
        end
    endgenerate

    assign rd_data = value_ff[rd_index];

endmodule // sgc_pwr_budget

//--- logic/sgc_ctl.v
// Switch global control: control register, fundamental reset sequence, quasi-reset hold,
// register lock, power budget unlock, downstream device number checks, broadcast drop.
// Assumes one register port shared by software, the SMBus slave and the EEPROM loader,
// with the source named on each request; the boot strap is an asynchronous pin.
`timescale 1ns/10ps
`include "sgc_regs.vh"

module sgc_ctl
(
    input wire clock,
    input wire rstn,
    input wire boot_reset_hold,
    input wire eeprom_load_done,
    input wire reg_req,
    input wire reg_we,
    input wire [1:0] reg_src,
    input wire [11:0] reg_addr,
    input wire [3:0] reg_be,
    input wire [31:0] reg_wdata,
    output reg reg_ack_ff,
    output reg reg_refused_ff,
    output reg [31:0] reg_rdata_ff,
    output wire quasi_reset,
    output wire fund_seq_done,
    output wire lock_release,
    output wire [7:0] dn_tlp_pass,
    output wire [7:0] dn_tlp_block,
    input wire [7:0] dn_tlp_valid,
    input wire [7:0] dn_tlp_id_routed,
    input wire [7:0] dn_tlp_cfg,
    input wire [7:0] dn_tlp_bus_hit,
    input wire [39:0] dn_tlp_devnum,
    input wire us_tlp_valid,
    input wire us_tlp_vdm_bcast,
    output reg us_tlp_fwd_ff,
    output reg us_tlp_drop_ff,
    output reg us_credit_return_ff
);

    localparam SEQ_SAMPLE = 2'h0;
    localparam SEQ_LOAD = 2'h1;
    localparam SEQ_HALT = 2'h2;
    localparam SEQ_RUN = 2'h3;

    reg [1:0] seq_ff;
    reg [1:0] nxt_seq;
    reg hold_meta_ff;
    reg hold_sync_ff;
    reg reset_hold_ff;
    reg nxt_reset_hold;
    reg lock_release_ff;
    reg nxt_lock_release;
    reg pbwe_ff;
    reg nxt_pbwe;
    reg [1:0] policy_ff;
    reg [1:0] nxt_policy;
    reg bdrop_ff;
    reg nxt_bdrop;
    reg boot_hold_ff;
    reg accept;
    reg [31:0] ctl_wr;
    reg [31:0] rd_mux;

    wire hit_ctl;
    wire hit_bcv;
    wire hit_pb;
    wire wr_go;
    wire pb_wr;
    wire [31:0] ctl_read;
    wire [31:0] pb_rdata;
    wire bcast_hit;
    wire rd_take;

    // Byte-lane merge of write data into an old value
    function [31:0] merge_be;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] be;
        begin
            merge_be = {be[3] ? new_val[31:24] : old_val[31:24],
                        be[2] ? new_val[23:16] : old_val[23:16],
                        be[1] ? new_val[15:8] : old_val[15:8],
                        be[0] ? new_val[7:0] : old_val[7:0]};
        end
    endfunction

    // Sources that may reach the registers before switching starts
    function hold_src_ok;
        input [1:0] src;
        begin
            hold_src_ok = (src == `SGC_SRC_SMB) || (src == `SGC_SRC_EEP);
        end
    endfunction

    assign hit_ctl = (reg_addr == `SGC_OFS_CTL);
    assign hit_bcv = (reg_addr == `SGC_OFS_BCV);
    assign hit_pb = (reg_addr[11:8] == `SGC_PB_PAGE) && (reg_addr[1:0] == 2'h0);

    assign quasi_reset = (seq_ff != SEQ_RUN);
    assign fund_seq_done = (seq_ff == SEQ_RUN);
    assign lock_release = lock_release_ff;

    // Software is shut out until switching starts; SMBus and the loader from the load state on, none during the strap sample state
    always @*
    begin
        case (seq_ff)
            SEQ_SAMPLE: accept = 1'b0;
            SEQ_LOAD: accept = hold_src_ok(reg_src);
            SEQ_HALT: accept = hold_src_ok(reg_src);
            SEQ_RUN: accept = 1'b1;
            default: accept = 1'b0;
        endcase
    end

    assign wr_go = reg_req & reg_we & accept;
    // Writes and refused reads answer zero
    assign rd_take = reg_req & ~reg_we & accept;

    assign ctl_read = {12'h000, bdrop_ff, 8'h00, policy_ff, 4'h0,
                       pbwe_ff, lock_release_ff, reset_hold_ff, 2'h0};

    // Boot strap crosses in through two flops
    always @(posedge clock)
    begin
        hold_meta_ff <= boot_reset_hold;
        hold_sync_ff <= hold_meta_ff;
    end

    // Fundamental reset sequence
    always @*
    begin
        nxt_seq = seq_ff;
        case (seq_ff)
            SEQ_SAMPLE: nxt_seq = SEQ_LOAD;
            SEQ_LOAD:
            begin
                if (eeprom_load_done)
                    nxt_seq = SEQ_HALT;
            end
            SEQ_HALT:
            begin
                if (!reset_hold_ff)
                    nxt_seq = SEQ_RUN;
            end
            SEQ_RUN: nxt_seq = SEQ_RUN;
            default: nxt_seq = SEQ_SAMPLE;
        endcase
    end

    // Control register next values
    always @*
    begin
        ctl_wr = merge_be(ctl_read, reg_wdata, reg_be) & `SGC_CTL_MASK;
        nxt_reset_hold = reset_hold_ff;
        nxt_lock_release = lock_release_ff;
        nxt_pbwe = pbwe_ff;
        nxt_policy = policy_ff;
        nxt_bdrop = bdrop_ff;
        if (wr_go && hit_ctl)
        begin
            // Hold is still stored after the sequence, it just steers nothing
            nxt_reset_hold = ctl_wr[`SGC_BIT_HOLD];
            nxt_lock_release = ctl_wr[`SGC_BIT_UNLOCK];
            if (lock_release_ff)
                nxt_pbwe = ctl_wr[`SGC_BIT_PBWE];
            nxt_policy = ctl_wr[`SGC_POL_HI:`SGC_POL_LO];
            nxt_bdrop = ctl_wr[`SGC_BIT_BDROP];
        end
        if (seq_ff == SEQ_SAMPLE)
        begin
            nxt_reset_hold = hold_sync_ff;
            nxt_lock_release = 1'b1;
        end
    end

    always @(posedge clock)
    begin
        if (!rstn)
        begin
            seq_ff <= SEQ_SAMPLE;
            reset_hold_ff <= 1'b0;
            lock_release_ff <= `SGC_RST_UNLOCK;
            pbwe_ff <= `SGC_RST_PBWE;
            policy_ff <= `SGC_RST_POL;
            bdrop_ff <= `SGC_RST_BDROP;
            boot_hold_ff <= 1'b0;
        end
        else
        begin
            seq_ff <= nxt_seq;
            reset_hold_ff <= nxt_reset_hold;
            lock_release_ff <= nxt_lock_release;
            pbwe_ff <= nxt_pbwe;
            policy_ff <= nxt_policy;
            bdrop_ff <= nxt_bdrop;
            if (seq_ff == SEQ_SAMPLE)
                boot_hold_ff <= hold_sync_ff;
        end
    end

    // Power budget values, writable only while their unlock is set
    assign pb_wr = wr_go & hit_pb & pbwe_ff;

    sgc_pwr_budget u_pwr_budget
    (
        .clock(clock),
        .rstn(rstn),
        .wr(pb_wr),
        .wr_index(reg_addr[7:2]),
        .wr_be(reg_be),
        .wr_data(reg_wdata),
        .rd_index(reg_addr[7:2]),
        .rd_data(pb_rdata)
    );

    // Read data; unmapped addresses read zero
    always @*
    begin
        rd_mux = 32'h00000000;
        if (hit_ctl)
            rd_mux = ctl_read;
        else if (hit_bcv)
        begin
            // Only the hold strap is kept; other boot fields read zero
            rd_mux[`SGC_BCV_HOLD] = boot_hold_ff;
        end
        else if (hit_pb)
            rd_mux = pb_rdata;
    end

    always @(posedge clock)
    begin
        if (!rstn)
        begin
            reg_ack_ff <= 1'b0;
            reg_refused_ff <= 1'b0;
            reg_rdata_ff <= 32'h00000000;
        end
        else
        begin
            reg_ack_ff <= reg_req;
            reg_refused_ff <= reg_req & ~accept;
            reg_rdata_ff <= rd_take ? rd_mux : 32'h00000000;
        end
    end

    // Downstream device number checks, one per port
    genvar p;
    generate
        for (p = 0; p < `SGC_NPORT; p = p + 1)
        begin : g_dn
            sgc_devnum_chk u_chk
            (
                .clock(clock),
                .rstn(rstn),
                .enable(~quasi_reset),
                .policy(policy_ff),
                .tlp_valid(dn_tlp_valid[p]),
                .tlp_id_routed(dn_tlp_id_routed[p]),
                .tlp_cfg(dn_tlp_cfg[p]),
                .tlp_bus_hit(dn_tlp_bus_hit[p]),
                .tlp_devnum(dn_tlp_devnum[5*p+4:5*p]),
                .pass_ff(dn_tlp_pass[p]),
                .block_ff(dn_tlp_block[p])
            );
        end
    endgenerate

    // Upstream vendor broadcast drop; no error flag exists to set
    assign bcast_hit = us_tlp_valid & us_tlp_vdm_bcast & bdrop_ff;

    always @(posedge clock)
    begin
        if (!rstn)
        begin
            us_tlp_fwd_ff <= 1'b0;
            us_tlp_drop_ff <= 1'b0;
            us_credit_return_ff <= 1'b0;
        end
        else
        begin
            us_tlp_fwd_ff <= ~quasi_reset & us_tlp_valid & ~bcast_hit;
            us_tlp_drop_ff <= ~quasi_reset & bcast_hit;
            us_credit_return_ff <= ~quasi_reset & bcast_hit;
        end
    end

endmodule // sgc_ctl

//--- testbench/sgc_ctl_sva.sv
// Port checker for the switch global control block.
// Bound into sgc_ctl; one clock, synchronous active-low reset.
`timescale 1ns/10ps
`include "sgc_regs.vh"
module sgc_ctl_chk
(
    input wire clock,
    input wire rstn,
    input wire reg_req,
    input wire reg_we,
    input wire [1:0] reg_src,
    input wire reg_ack_ff,
    input wire reg_refused_ff,
    input wire [31:0] reg_rdata_ff,
    input wire quasi_reset,
    input wire fund_seq_done,
    input wire lock_release,
    input wire [7:0] dn_tlp_pass,
    input wire [7:0] dn_tlp_block,
    input wire [7:0] dn_tlp_valid,
    input wire [7:0] dn_tlp_id_routed,
    input wire us_tlp_valid,
    input wire us_tlp_vdm_bcast,
    input wire us_tlp_fwd_ff,
    input wire us_tlp_drop_ff,
    input wire us_credit_return_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_sw_held;
        reg_req && reg_src == `SGC_SRC_SW && quasi_reset;
    endsequence
    sequence s_no_write;
        !(reg_req && reg_we) && fund_seq_done;
    endsequence
    chk_ack_every_req: assert property (reg_req |=> reg_ack_ff)
        else $error("ack missing");
    chk_ack_has_req: assert property (reg_ack_ff |-> $past(reg_req))
        else $error("ack without request");
    chk_sw_refused: assert property (s_sw_held |=> reg_refused_ff)
        else $error("software access taken in hold");
    chk_refused_zero: assert property (reg_refused_ff |-> reg_rdata_ff == 32'h00000000)
        else $error("refused access returned data");
    chk_done_inverse: assert property (fund_seq_done == !quasi_reset)
        else $error("done not inverse of hold");
    chk_dn_quiet: assert property (quasi_reset |=> dn_tlp_pass == 8'h00 && dn_tlp_block == 8'h00)
        else $error("downstream active in hold");
    chk_us_quiet: assert property (quasi_reset |=> !(us_tlp_fwd_ff || us_tlp_drop_ff))
        else $error("upstream active in hold");
    chk_plain_pass: assert property (dn_tlp_valid[3] && !dn_tlp_id_routed[3] && !quasi_reset
        |=> dn_tlp_pass[3] && !dn_tlp_block[3])
        else $error("plain TLP not delivered");
    chk_drop_credit: assert property (us_tlp_drop_ff |-> us_credit_return_ff && !us_tlp_fwd_ff)
        else $error("drop without credit");
    chk_fwd_plain: assert property (us_tlp_valid && !us_tlp_vdm_bcast && !quasi_reset |=> us_tlp_fwd_ff)
        else $error("plain upstream TLP not forwarded");
    chk_lock_hold: assert property (s_no_write |=> $stable(lock_release))
        else $error("unlock changed without write");
endmodule // sgc_ctl_chk

bind sgc_ctl sgc_ctl_chk u_chk (.clock(clock), .rstn(rstn), .reg_req(reg_req), .reg_we(reg_we),
    .reg_src(reg_src), .reg_ack_ff(reg_ack_ff), .reg_refused_ff(reg_refused_ff),
    .reg_rdata_ff(reg_rdata_ff), .quasi_reset(quasi_reset), .fund_seq_done(fund_seq_done),
    .lock_release(lock_release), .dn_tlp_pass(dn_tlp_pass), .dn_tlp_block(dn_tlp_block),
    .dn_tlp_valid(dn_tlp_valid), .dn_tlp_id_routed(dn_tlp_id_routed), .us_tlp_valid(us_tlp_valid),
    .us_tlp_vdm_bcast(us_tlp_vdm_bcast), .us_tlp_fwd_ff(us_tlp_fwd_ff),
    .us_tlp_drop_ff(us_tlp_drop_ff), .us_credit_return_ff(us_credit_return_ff));

//--- testbench/sgc_ctl_test.sv
// Self-checking bench for the switch global control block.
// Drives every port of sgc_ctl directly; strap high at first, low across a second reset.
`timescale 1ns/10ps
`include "sgc_regs.vh"
module sgc_ctl_test;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg eld = 1'b0;
    reg bh = 1'b1;
    reg req = 1'b0;
    reg we = 1'b0;
    reg [1:0] src = 2'h0;
    reg [11:0] adr = 12'h000;
    reg [31:0] wd = 32'h00000000;
    // Fixed pattern: port0 any TLP, port1 cfg, port2 devnum 0, port3 not ID-routed
    reg [7:0] dv = 8'h00, di = 8'h07, dc = 8'h0E, dh = 8'h0F;
    reg [39:0] dd = 40'h0000018063;
    reg uv = 1'b0, ub = 1'b0;
    wire ack, refd, qr, done, lk, fwd, drop, cred;
    wire [31:0] rdata;
    wire [7:0] pass, blk;
    integer mismatches = 0;
    integer samples_checked = 0;
    integer p;
    always #4 clock = ~clock;
    sgc_ctl dut (.clock(clock), .rstn(rstn), .boot_reset_hold(bh), .eeprom_load_done(eld),
        .reg_req(req), .reg_we(we), .reg_src(src), .reg_addr(adr), .reg_be(4'hF), .reg_wdata(wd),
        .reg_ack_ff(ack), .reg_refused_ff(refd), .reg_rdata_ff(rdata), .quasi_reset(qr),
        .fund_seq_done(done), .lock_release(lk), .dn_tlp_pass(pass), .dn_tlp_block(blk),
        .dn_tlp_valid(dv), .dn_tlp_id_routed(di), .dn_tlp_cfg(dc), .dn_tlp_bus_hit(dh),
        .dn_tlp_devnum(dd), .us_tlp_valid(uv), .us_tlp_vdm_bcast(ub), .us_tlp_fwd_ff(fwd),
        .us_tlp_drop_ff(drop), .us_credit_return_ff(cred));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // One access: request held for one edge, answer taken just after that same edge
    task acc(input [1:0] s, input w, input [11:0] a, input [31:0] d, input e_ref, input [31:0] e_q);
        begin
            @(posedge clock);
            #1;
            req = 1'b1;
            we = w;
            src = s;
            adr = a;
            wd = d;
            @(posedge clock);
            #1;
            req = 1'b0;
            chk(ack, 1'b1);
            chk(refd, e_ref);
            chk(rdata, e_q);
        end
    endtask
    task cw(input [1:0] s, input [31:0] d, input [31:0] e);
        begin
            acc(s, 1'b1, `SGC_OFS_CTL, d, 1'b0, 32'h0);
            acc(s, 1'b0, `SGC_OFS_CTL, 32'h0, 1'b0, e);
        end
    endtask
    // Inputs set by the caller are taken at the next edge
    task tlp(input [7:0] eb, input [7:0] ep, input [2:0] eu);
        begin
            @(posedge clock);
            #1;
            dv = 8'h00;
            uv = 1'b0;
            chk(blk, eb);
            chk(pass, ep);
            chk({fwd, drop, cred}, eu);
        end
    endtask
    task t_hold;
        begin
            chk(qr, 1'b1);
            acc(`SGC_SRC_SW, 1'b1, `SGC_OFS_CTL, 32'h0, 1'b1, 32'h0);
            acc(`SGC_SRC_SMB, 1'b0, `SGC_OFS_BCV, 32'h0, 1'b0, 32'h00010000);
            acc(`SGC_SRC_SMB, 1'b0, `SGC_OFS_CTL, 32'h0, 1'b0, 32'h0000000C);
            dv = 8'h0F;
            uv = 1'b1;
            tlp(8'h00, 8'h00, 3'b000);
        end
    endtask
    task t_lock;
        begin
            cw(`SGC_SRC_SMB, 32'hFFFFFFFF, `SGC_CTL_MASK);
            cw(`SGC_SRC_SMB, 32'h00000014, 32'h00000014);
            cw(`SGC_SRC_SMB, 32'h00000004, 32'h00000014);
            cw(`SGC_SRC_SMB, 32'h0000000C, 32'h0000001C);
            cw(`SGC_SRC_SMB, 32'h0000000C, 32'h0000000C);
            chk(lk, 1'b1);
        end
    endtask
    task t_pbv;
        begin
            acc(`SGC_SRC_SMB, 1'b1, 12'h124, 32'hA5A5A5A5, 1'b0, 32'h0);
            acc(`SGC_SRC_SMB, 1'b0, 12'h124, 32'h0, 1'b0, 32'h0);
            cw(`SGC_SRC_SMB, 32'h0000001C, 32'h0000001C);
            acc(`SGC_SRC_SMB, 1'b1, 12'h124, 32'hA5A5A5A5, 1'b0, 32'h0);
            acc(`SGC_SRC_SMB, 1'b0, 12'h124, 32'h0, 1'b0, 32'hA5A5A5A5);
            cw(`SGC_SRC_SMB, 32'h0000000C, 32'h0000000C);
            acc(`SGC_SRC_SMB, 1'b1, 12'h124, 32'h0, 1'b0, 32'h0);
            acc(`SGC_SRC_SMB, 1'b0, 12'h124, 32'h0, 1'b0, 32'hA5A5A5A5);
        end
    endtask
    task t_run;
        begin
            eld = 1'b1;
            cw(`SGC_SRC_SMB, 32'h0000000C, 32'h0000000C);
            chk(qr, 1'b1);
            cw(`SGC_SRC_SMB, 32'h00000008, 32'h00000008);
            p = 0;
            while (done !== 1'b1 && p < 20)
            begin
                @(posedge clock);
                #1;
                p = p + 1;
            end
            chk(done, 1'b1);
            cw(`SGC_SRC_SW, 32'h0000000C, 32'h0000000C);
            repeat (3) @(posedge clock);
            chk(qr, 1'b0);
        end
    endtask
    task t_dev;
        reg [7:0] eb;
        begin
            for (p = 0; p < 4; p = p + 1)
            begin
                eb = (p == 1) ? 8'h02 : ((p == 2) ? 8'h00 : 8'h03);
                cw(`SGC_SRC_SW, (p << 9) | 32'h8, (p << 9) | 32'h8);
                dv = 8'h0F;
                tlp(eb, 8'h0F & ~eb, 3'b000);
            end
        end
    endtask
    task t_bdrop;
        begin
            cw(`SGC_SRC_SW, 32'h00000008, 32'h00000008);
            uv = 1'b1;
            ub = 1'b1;
            tlp(8'h00, 8'h00, 3'b100);
            cw(`SGC_SRC_SW, 32'h00080008, 32'h00080008);
            uv = 1'b1;
            tlp(8'h00, 8'h00, 3'b011);
            uv = 1'b1;
            ub = 1'b0;
            tlp(8'h00, 8'h00, 3'b100);
            acc(`SGC_SRC_SW, 1'b0, 12'h040, 32'h0, 1'b0, 32'h0);
        end
    endtask
    // Second reset with the strap low: no hold stage, switching starts by itself
    task t_strap;
        begin
            bh = 1'b0;
            rstn = 1'b0;
            repeat (6) @(posedge clock);
            #1;
            chk(lk, 1'b0);
            rstn = 1'b1;
            acc(`SGC_SRC_SMB, 1'b0, `SGC_OFS_BCV, 32'h0, 1'b0, 32'h0);
            acc(`SGC_SRC_SMB, 1'b0, `SGC_OFS_CTL, 32'h0, 1'b0, 32'h00000008);
            chk(qr, 1'b0);
            chk(done, 1'b1);
        end
    endtask
    initial
    begin
        #20000;
        mismatches = mismatches + 1;
        close_out;
    end
    initial
    begin
        repeat (6) @(posedge clock);
        #1;
        chk(lk, 1'b0);
        rstn = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        t_hold;
        t_lock;
        t_pbv;
        t_run;
        t_dev;
        t_bdrop;
        t_strap;
        close_out;
    end
endmodule // sgc_ctl_test
